/* include/tweep_params.svh */
// shared constants for the two-wire eeprom target and its bus controller
`ifndef TWEEP_PARAMS_SVH
`define TWEEP_PARAMS_SVH
`define TWEEP_CLOCK_HZ 25000000
`define TWEEP_T_PROG_MS 5
`define TWEEP_ARRAY_BYTES 512
`define TWEEP_PAGE_BYTES 16
`define TWEEP_DEV_PREFIX 4'ha
`define TWEEP_RECOVER_BITS 18
`define TWEEP_REG_CMD 8'h00
`define TWEEP_REG_STATUS 8'h04
`define TWEEP_REG_DIV 8'h08
`define TWEEP_DIV_RST 8'h02
`define TWEEP_CMD_OP_LSB 8
`define TWEEP_ST_BUSY 0
`define TWEEP_ST_ACK 1
`define TWEEP_ST_DATA_LSB 8
`define TWEEP_OP_START 3'h1
`define TWEEP_OP_STOP 3'h2
`define TWEEP_OP_WRITE 3'h3
`define TWEEP_OP_READ_ACK 3'h4
`define TWEEP_OP_READ_NACK 3'h5
`define TWEEP_OP_RECOVER 3'h6
`endif

/* include/tweep_pkg.sv */
// types shared by the eeprom target and its bus controller
package tweep_pkg;
    typedef enum logic [2:0] {DEV_IDLE, DEV_RX, DEV_ACK, DEV_TX, DEV_RACK, DEV_PROG} tweep_dev_state_e;
    typedef enum logic [1:0] {PH_DEV, PH_WORD, PH_DATA} tweep_phase_e;
    typedef enum logic [1:0] {SLOT_START, SLOT_STOP, SLOT_BIT} tweep_slot_e;
    typedef logic [2:0] tweep_op_t;
endpackage : tweep_pkg

/* include/tweep_if.sv */
// two-wire link between bus controller and eeprom target
`timescale 1ns/1ps
`default_nettype none
interface tweep_if;
    logic scl;
    logic host_sda_oe;
    logic dev_sda_oe;
    wire sda;
    // open-drain data line with pull-up: any enabled driver pulls it low
    assign sda = ~(host_sda_oe | dev_sda_oe);
    modport host (output scl, output host_sda_oe, input sda);
    modport device (input scl, input sda, output dev_sda_oe);
endinterface : tweep_if
`default_nettype wire

/* verilog/tweep_device.sv */
// two-wire eeprom target: start/stop, addressing, acks, 512-byte array, self-timed programming
// Behaviour
// - sample on scl rise, shift out on fall
// - sda only pulled low or released
// - open chip-select straps count as low
// - write protect high blocks all programming
// - 32 pages of 16 bytes, 9-bit address
// - controller changes sda only while scl low
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - stop: read to standby, write programs first
// - acknowledge each byte on ninth clock
// - standby after reset, read stop, programming
// - start, eighteen ones, start resets protocol
// - address prefix 1010, others are ignored
// - straps match address bits five and six
// - seventh address bit is array address msb; the code takes it on writes only
// - eighth address bit selects read or write
// - programming self-timed, within 5 ms of stop
// - full and partial page writes accepted
// - no acknowledge while programming runs
// - page write increments low four bits only
// - counter increments per read, wraps at top
// - byte write: address, word, data, stop
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tweep_params.svh"

module tweep_device
    import tweep_pkg::*;
#(
    parameter int PROG_CYCLES = `TWEEP_T_PROG_MS * (`TWEEP_CLOCK_HZ / 1000)
) (
    input wire logic clock,
    input wire logic srst,
    tweep_if.device link,
    input wire logic chip_select_strap_high,
    input wire logic chip_select_strap_low,
    input wire logic write_protect,
    output logic programming
);

    localparam int PAGE = `TWEEP_PAGE_BYTES;

    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_s;
    logic sda_s;
    logic strap_hi_s;
    logic strap_lo_s;
    logic wp_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;
    tweep_dev_state_e state_reg;
    tweep_phase_e phase_reg;
    logic [3:0] bit_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic [8:0] addr_reg;
    logic rw_reg;
    logic mack_reg;
    logic sda_oe_reg;
    logic busy_reg;
    logic addr_hit;
    logic data_take;
    logic [7:0] rd_byte;
    logic [7:0] mem_array [0:`TWEEP_ARRAY_BYTES-1];
    logic [7:0] page_buf [0:PAGE-1];
    logic [PAGE-1:0] page_mask_reg;
    logic [31:0] prog_cnt_reg;

    // every pin from outside passes two flops before any logic reads it
    always_ff @(posedge clock) begin
        if (srst) begin
            sync1_reg <= 5'h18;
            sync2_reg <= 5'h18;
        end else begin
            sync1_reg <= {link.scl, link.sda, chip_select_strap_high, chip_select_strap_low, write_protect};
            sync2_reg <= sync1_reg;
        end
    end

    // delayed copies of the synchronised bus lines for edge finding
    always_ff @(posedge clock) begin
        if (srst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_s = sync2_reg[4];
    assign sda_s = sync2_reg[3];
    // strap levels; an open strap is tied low at the pad
    assign strap_hi_s = sync2_reg[2];
    assign strap_lo_s = sync2_reg[1];
    assign wp_s = sync2_reg[0];
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    // start: data falls while clock stays high
    assign start_det = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
    // stop: data rises while clock stays high
    assign stop_det = scl_s & scl_d_reg & sda_s & ~sda_d_reg;
    assign byte_done = (state_reg == DEV_RX) && scl_fall && (bit_reg == 4'd8);
    // prefix check, strap match on bits five and six
    assign addr_hit = (rx_reg[7:4] == `TWEEP_DEV_PREFIX) && (rx_reg[3:2] == {strap_hi_s, strap_lo_s});
    assign data_take = byte_done && (phase_reg == PH_DATA);
    // nine-bit address into 32 pages of 16 bytes
    assign rd_byte = mem_array[addr_reg];

    // protocol engine; start and stop outrank bit events
    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= DEV_IDLE;
            phase_reg <= PH_DEV;
            bit_reg <= 4'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            addr_reg <= 9'h000;
            rw_reg <= 1'b0;
            mack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (state_reg == DEV_PROG) begin
            // bus ignored while programming, so no address is acknowledged
            if (prog_cnt_reg == 32'(PROG_CYCLES - 1)) begin
                state_reg <= DEV_IDLE;
            end
        end else if (start_det) begin
            // a start abandons any word; recovery ends here too
            state_reg <= DEV_RX;
            phase_reg <= PH_DEV;
            bit_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
        end else if (stop_det) begin
            // buffered write data goes to programming, else standby
            // write protect keeps the array untouched
            sda_oe_reg <= 1'b0;
            if (page_mask_reg != '0 && !wp_s) begin
                state_reg <= DEV_PROG;
            end else begin
                state_reg <= DEV_IDLE;
            end
        end else begin
            case (state_reg)
                DEV_RX: begin
                    // data taken on the rising clock edge
                    if (scl_rise) begin
                        rx_reg <= {rx_reg[6:0], sda_s};
                        bit_reg <= bit_reg + 4'd1;
                    end else if (byte_done) begin
                        bit_reg <= 4'h0;
                        // pull data low through the ninth clock
                        sda_oe_reg <= 1'b1;
                        state_reg <= DEV_ACK;
                        case (phase_reg)
                            PH_DEV: begin
                                if (addr_hit) begin
                                    // last bit chooses read or write
                                    rw_reg <= rx_reg[0];
                                    // page select bit becomes the address msb on writes
                                    if (!rx_reg[0]) begin
                                        addr_reg[8] <= rx_reg[1];
                                    end
                                end else begin
                                    // foreign or mismatched address: silent standby
                                    sda_oe_reg <= 1'b0;
                                    state_reg <= DEV_IDLE;
                                end
                            end
                            PH_WORD: begin
                                addr_reg[7:0] <= rx_reg;
                            end
                            default: begin
                                // column wraps inside the page, row is held
                                addr_reg[3:0] <= addr_reg[3:0] + 4'd1;
                            end
                        endcase
                    end
                end
                DEV_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg && phase_reg == PH_DEV) begin
                            // first data bit goes out on this falling edge
                            state_reg <= DEV_TX;
                            tx_reg <= rd_byte;
                            // only a low is ever driven
                            sda_oe_reg <= ~rd_byte[7];
                        end else begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= DEV_RX;
                            phase_reg <= (phase_reg == PH_DEV) ? PH_WORD : PH_DATA;
                        end
                    end
                end
                DEV_TX: begin
                    if (scl_fall) begin
                        bit_reg <= bit_reg + 4'd1;
                        if (bit_reg == 4'd7) begin
                            // release for the controller's acknowledge
                            sda_oe_reg <= 1'b0;
                            state_reg <= DEV_RACK;
                            // full counter increments and wraps at the top
                            addr_reg <= addr_reg + 9'd1;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sda_oe_reg <= ~tx_reg[6];
                        end
                    end
                end
                DEV_RACK: begin
                    if (scl_rise) begin
                        mack_reg <= ~sda_s;
                    end else if (scl_fall) begin
                        bit_reg <= 4'h0;
                        if (mack_reg) begin
                            state_reg <= DEV_TX;
                            tx_reg <= rd_byte;
                            sda_oe_reg <= ~rd_byte[7];
                        end else begin
                            // no acknowledge: wait in standby for the stop
                            state_reg <= DEV_IDLE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // page buffer; a start drops an unfinished write so a dummy write never programs,
    // and the mask survives programming until the cycle after it ends, since commit reads it
    always_ff @(posedge clock) begin
        if (srst) begin
            page_mask_reg <= '0;
        end else if (state_reg != DEV_PROG && (start_det || busy_reg)) begin
            page_mask_reg <= '0;
        end else if (data_take) begin
            // any count of bytes; a 17th byte rolls over the 1st
            page_mask_reg[addr_reg[3:0]] <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (data_take) begin
            page_buf[addr_reg[3:0]] <= rx_reg;
        end
    end

    // self-timed interval counter, idle at zero outside programming
    always_ff @(posedge clock) begin
        if (srst || state_reg != DEV_PROG) begin
            prog_cnt_reg <= 32'h0;
        end else begin
            prog_cnt_reg <= prog_cnt_reg + 32'd1;
        end
    end

    // commit one buffered byte per cycle; the old byte is replaced whole
    always_ff @(posedge clock) begin
        if (state_reg == DEV_PROG && prog_cnt_reg < 32'(PAGE) && page_mask_reg[prog_cnt_reg[3:0]]) begin
            mem_array[{addr_reg[8:4], prog_cnt_reg[3:0]}] <= page_buf[prog_cnt_reg[3:0]];
        end
    end

    // busy flag lags the state by one cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_reg == DEV_PROG);
        end
    end

    assign programming = busy_reg;
    assign link.dev_sda_oe = sda_oe_reg;

endmodule : tweep_device
`default_nettype wire

/* verilog/tweep_host.sv */
// two-wire bus controller driven by software over apb
`timescale 1ns/1ps
`default_nettype none
`include "tweep_params.svh"

module tweep_host
    import tweep_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    tweep_if.host link
);

    logic sda_sync1_reg;
    logic sda_sync2_reg;
    logic setup;
    logic access;
    logic cmd_wr;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [7:0] div_reg;
    tweep_op_t op_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic ack_reg;
    logic busy_reg;
    logic [7:0] cnt_reg;
    logic [1:0] q_reg;
    logic [4:0] slot_reg;
    logic [4:0] last_slot;
    logic tick;
    tweep_slot_e slot_kind;
    logic slot_bit;
    logic scl_lvl;
    logic oe_lvl;
    logic scl_reg;
    logic sda_oe_reg;

    // data line comes back through two flops
    always_ff @(posedge clock) begin
        if (srst) begin
            sda_sync1_reg <= 1'b1;
            sda_sync2_reg <= 1'b1;
        end else begin
            sda_sync1_reg <= link.sda;
            sda_sync2_reg <= sda_sync1_reg;
        end
    end

    assign setup = psel && !penable;
    assign access = psel && penable && pready_reg;
    // commands arriving while busy are dropped; software polls the busy bit
    assign cmd_wr = access && pwrite && paddr == `TWEEP_REG_CMD && !busy_reg;

    // read data and ready registered in the setup cycle: no wait states
    always_ff @(posedge clock) begin
        if (srst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= setup;
            if (setup) begin
                pslverr_reg <= 1'b0;
                prdata_reg <= 32'h0;
                case (paddr)
                    `TWEEP_REG_CMD: prdata_reg <= {21'h0, op_reg, tx_reg};
                    `TWEEP_REG_STATUS: prdata_reg <= {16'h0, rx_reg, 6'h0, ack_reg, busy_reg};
                    `TWEEP_REG_DIV: prdata_reg <= {24'h0, div_reg};
                    default: pslverr_reg <= 1'b1;
                endcase
            end
        end
    end

    // quarter-bit divider; four quarters make one link clock period
    always_ff @(posedge clock) begin
        if (srst) begin
            div_reg <= `TWEEP_DIV_RST;
        end else if (access && pwrite && paddr == `TWEEP_REG_DIV) begin
            div_reg <= pwdata[7:0];
        end
    end

    assign tick = ({1'b0, cnt_reg} + 9'd1) >= {1'b0, div_reg};

    // slot shape for the current command
    always_comb begin
        slot_kind = SLOT_BIT;
        slot_bit = 1'b1;
        last_slot = 5'd8;
        case (op_reg)
            `TWEEP_OP_START: begin
                slot_kind = SLOT_START;
                last_slot = 5'd0;
            end
            `TWEEP_OP_STOP: begin
                slot_kind = SLOT_STOP;
                last_slot = 5'd0;
            end
            `TWEEP_OP_WRITE: slot_bit = (slot_reg < 5'd8) ? tx_reg[7] : 1'b1;
            `TWEEP_OP_READ_ACK: slot_bit = (slot_reg < 5'd8);
            `TWEEP_OP_RECOVER: begin
                last_slot = 5'(`TWEEP_RECOVER_BITS + 1);
                if (slot_reg == 5'd0 || slot_reg == last_slot) begin
                    slot_kind = SLOT_START;
                end
            end
            default: begin
            end
        endcase
    end

    // line levels per quarter
    always_comb begin
        case (slot_kind)
            // data falls in the third quarter with clock high
            SLOT_START: begin
                scl_lvl = (q_reg == 2'd1) || (q_reg == 2'd2);
                oe_lvl = q_reg[1];
            end
            // data rises in the third quarter, clock stays high
            SLOT_STOP: begin
                scl_lvl = (q_reg != 2'd0);
                oe_lvl = !q_reg[1];
            end
            // data set in quarter zero while clock is low
            default: begin
                scl_lvl = (q_reg == 2'd1) || (q_reg == 2'd2);
                oe_lvl = !slot_bit;
            end
        endcase
    end

    // sequencer: quarters within slots within one command
    always_ff @(posedge clock) begin
        if (srst) begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
            q_reg <= 2'd0;
            slot_reg <= 5'd0;
        end else if (cmd_wr) begin
            busy_reg <= 1'b1;
            cnt_reg <= 8'h00;
            q_reg <= 2'd0;
            slot_reg <= 5'd0;
        end else if (busy_reg) begin
            if (tick) begin
                cnt_reg <= 8'h00;
                q_reg <= q_reg + 2'd1;
                if (q_reg == 2'd3) begin
                    slot_reg <= slot_reg + 5'd1;
                    if (slot_reg == last_slot) begin
                        busy_reg <= 1'b0;
                    end
                end
            end else begin
                cnt_reg <= cnt_reg + 8'd1;
            end
        end
    end

    // command data: load, shift out, sample at the end of the high time
    always_ff @(posedge clock) begin
        if (srst) begin
            op_reg <= `TWEEP_OP_STOP;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else if (cmd_wr) begin
            op_reg <= pwdata[`TWEEP_CMD_OP_LSB +: 3];
            tx_reg <= pwdata[7:0];
        end else if (busy_reg && tick && slot_reg < 5'd8) begin
            if (q_reg == 2'd3) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
            if (q_reg == 2'd2) begin
                rx_reg <= {rx_reg[6:0], sda_sync2_reg};
            end
        end else if (busy_reg && tick && q_reg == 2'd2 && op_reg == `TWEEP_OP_WRITE) begin
            // each byte is checked for the target's acknowledge
            ack_reg <= !sda_sync2_reg;
        end
    end

    // pins follow the sequencer one cycle late; idle keeps last levels
    always_ff @(posedge clock) begin
        if (srst) begin
            scl_reg <= 1'b1;
            sda_oe_reg <= 1'b0;
        end else if (busy_reg) begin
            scl_reg <= scl_lvl;
            sda_oe_reg <= oe_lvl;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign link.scl = scl_reg;
    assign link.host_sda_oe = sda_oe_reg;

endmodule : tweep_host
`default_nettype wire

/* test/tweep_link_props.sv */
// concurrent checks on the two-wire link between bus controller and eeprom target
`timescale 1ns/1ps
`default_nettype none
module tweep_link_props #(
    parameter int PROG_CYCLES = 64
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic scl,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic sda,
    input wire logic programming
);
    logic [7:0] since_stop;
    logic [15:0] prog_len;
    logic sda_q;
    // stop age saturates so a late programming start cannot alias a fresh stop
    always_ff @(posedge clock) begin
        sda_q <= sda;
        if (srst) begin
            since_stop <= 8'hff;
        end else if (scl && sda && !sda_q) begin
            since_stop <= 8'h00;
        end else if (since_stop != 8'hff) begin
            since_stop <= since_stop + 8'h01;
        end
    end
    // length of the running programming pulse
    always_ff @(posedge clock) begin
        if (srst || !programming) begin
            prog_len <= 16'h0000;
        end else begin
            prog_len <= prog_len + 16'h0001;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    a_dev_shift_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data moved while scl high");
    a_reset_idle: assert property ($fell(srst) |-> scl && !host_sda_oe && !dev_sda_oe && !programming)
        else $error("link not idle after reset");
    a_prog_silent: assert property (programming |-> !dev_sda_oe)
        else $error("device drove sda while programming");
    a_prog_bounded: assert property (programming |-> prog_len <= PROG_CYCLES + 4)
        else $error("programming ran too long");
    a_prog_after_stop: assert property ($rose(programming) |-> since_stop <= 8'd16)
        else $error("programming started without a stop");
    a_ack_holds: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout (##[1:16] $rose(scl) ##1 scl [*2]))
        else $error("device low level not held over scl high");
    a_start_quiet: assert property (scl && $fell(sda) |=> !dev_sda_oe [*8])
        else $error("device drove sda right after start");
    a_stop_quiet: assert property (scl && $rose(sda) |=> !dev_sda_oe [*8])
        else $error("device drove sda right after stop");
    c_prog: cover property ($rose(programming));
    c_ack: cover property ($rose(dev_sda_oe));
    c_start: cover property (scl && $fell(sda));
endmodule : tweep_link_props
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench: apb-driven bus controller facing the eeprom target
`timescale 1ns/1ps
`default_nettype none
`include "tweep_params.svh"
module tb_top
    import tweep_pkg::*;
;
    localparam int PROG = 2000; // long enough to poll for an ack while programming
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cs_hi = 1'b0;
    logic cs_lo = 1'b0;
    logic wp = 1'b0;
    logic programming;
    logic [31:0] st;
    int fail_count = 0;
    int n_checks = 0;
    tweep_if lnk ();
    tweep_host tweep_host_i (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
    tweep_device #(.PROG_CYCLES(PROG)) tweep_device_i (.clock(clock), .srst(srst), .link(lnk),
        .chip_select_strap_high(cs_hi), .chip_select_strap_low(cs_lo), .write_protect(wp),
        .programming(programming));
    tweep_link_props #(.PROG_CYCLES(PROG)) tweep_link_props_i (.clock(clock), .srst(srst), .scl(lnk.scl),
        .host_sda_oe(lnk.host_sda_oe), .dev_sda_oe(lnk.dev_sda_oe), .sda(lnk.sda), .programming(programming));
    // free-running 25 mhz clock
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : check
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : apb
    // issue a command, then poll busy under a bound
    task automatic cmd(input tweep_op_t op, input logic [7:0] b);
        logic e;
        int i;
        apb(1'b1, `TWEEP_REG_CMD, {21'h0, op, b}, st, e);
        st = 32'h1;
        i = 0;
        while (st[`TWEEP_ST_BUSY] !== 1'b0) begin
            apb(1'b0, `TWEEP_REG_STATUS, 32'h0, st, e);
            i++;
            if (i > 400) begin
                fail_count++;
                tally_and_finish();
            end
        end
    endtask : cmd
    task automatic wr(input logic [7:0] b, input logic a);
        cmd(`TWEEP_OP_WRITE, b);
        check("ack", a, st[`TWEEP_ST_ACK]);
    endtask : wr
    task automatic rd(input tweep_op_t op, input logic [7:0] x);
        cmd(op, 8'h00);
        check("rdata", x, st[15:8]);
    endtask : rd
    task automatic bwrite(input logic [7:0] dev, input logic [7:0] w, input logic [7:0] d);
        cmd(`TWEEP_OP_START, 8'h00);
        wr(dev, 1'b1);
        wr(w, 1'b1);
        wr(d, 1'b1);
        cmd(`TWEEP_OP_STOP, 8'h00);
    endtask : bwrite
    // dummy write sets the counter, then a current-address read
    task automatic rread(input logic [7:0] dev, input logic [7:0] w, input logic [7:0] x);
        cmd(`TWEEP_OP_START, 8'h00);
        wr(dev, 1'b1);
        wr(w, 1'b1);
        cmd(`TWEEP_OP_START, 8'h00);
        wr(dev | 8'h01, 1'b1);
        rd(`TWEEP_OP_READ_NACK, x);
        cmd(`TWEEP_OP_STOP, 8'h00);
    endtask : rread
    task automatic prog_wait();
        int i;
        i = 0;
        while (programming !== 1'b0) begin
            @(posedge clock);
            i++;
            if (i > 4000) begin
                fail_count++;
                tally_and_finish();
            end
        end
    endtask : prog_wait
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        apb(1'b0, `TWEEP_REG_DIV, 32'h0, q, e);
        check("div", 32'(`TWEEP_DIV_RST), q);
        apb(1'b0, 8'h0c, 32'h0, q, e);
        check("unmapped_err", 32'h1, e);
        check("unmapped_data", 32'h0, q);
    endtask : t_regs
    task automatic t_byte_write();
        bwrite(8'ha0, 8'h05, 8'h5a);
        cmd(`TWEEP_OP_START, 8'h00);
        wr(8'ha0, 1'b0);
        cmd(`TWEEP_OP_STOP, 8'h00);
        check("programming", 32'h1, programming);
        prog_wait();
        rread(8'ha0, 8'h05, 8'h5a);
    endtask : t_byte_write
    task automatic t_wp_and_addr();
        logic seen;
        cmd(`TWEEP_OP_START, 8'h00);
        wr(8'hb0, 1'b0);
        cmd(`TWEEP_OP_START, 8'h00);
        wr(8'ha4, 1'b0);
        cmd(`TWEEP_OP_STOP, 8'h00);
        cs_hi <= 1'b1;
        wp <= 1'b1;
        cmd(`TWEEP_OP_START, 8'h00);
        wr(8'ha0, 1'b0);
        bwrite(8'ha8, 8'h05, 8'hc3);
        seen = 1'b0;
        repeat (40) begin
            @(posedge clock);
            seen |= (programming === 1'b1);
        end
        check("wp_prog", 32'h0, seen);
        cs_hi <= 1'b0;
        wp <= 1'b0;
        rread(8'ha0, 8'h05, 8'h5a);
    endtask : t_wp_and_addr
    task automatic t_page_wrap();
        cmd(`TWEEP_OP_START, 8'h00);
        wr(8'ha0, 1'b1);
        wr(8'h1e, 1'b1);
        wr(8'h11, 1'b1);
        wr(8'h22, 1'b1);
        wr(8'h33, 1'b1);
        cmd(`TWEEP_OP_STOP, 8'h00);
        prog_wait();
        rread(8'ha0, 8'h10, 8'h33);
        rread(8'ha0, 8'h1e, 8'h11);
    endtask : t_page_wrap
    task automatic t_seq_wrap();
        bwrite(8'ha2, 8'hff, 8'h77);
        prog_wait();
        bwrite(8'ha0, 8'h00, 8'h99);
        prog_wait();
        cmd(`TWEEP_OP_START, 8'h00);
        wr(8'ha2, 1'b1);
        wr(8'hff, 1'b1);
        cmd(`TWEEP_OP_START, 8'h00);
        wr(8'ha1, 1'b1);
        rd(`TWEEP_OP_READ_ACK, 8'h77);
        rd(`TWEEP_OP_READ_NACK, 8'h99);
        cmd(`TWEEP_OP_STOP, 8'h00);
    endtask : t_seq_wrap
    // slower link, then an interrupted transfer recovered by the soft sequence
    task automatic t_recover();
        logic [31:0] q;
        logic e;
        apb(1'b1, `TWEEP_REG_DIV, 32'h3, q, e);
        apb(1'b0, `TWEEP_REG_DIV, 32'h0, q, e);
        check("div_set", 32'h3, q);
        cmd(`TWEEP_OP_START, 8'h00);
        wr(8'ha0, 1'b1);
        cmd(`TWEEP_OP_RECOVER, 8'h00);
        wr(8'ha0, 1'b1);
        rread(8'ha0, 8'h05, 8'h5a);
    endtask : t_recover
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        t_regs();
        t_byte_write();
        t_wp_and_addr();
        t_page_wrap();
        t_seq_wrap();
        t_recover();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
